// ---- rtcm_regs.vh ----
// register map constants for the real-time clock register block
// assumes byte-wide locations reached by a five-bit location index
`ifndef RTCM_REGS_VH
`define RTCM_REGS_VH

// ****************************************************************
// location indices
// ****************************************************************
`define RTCM_SUB_SECONDS        5'h00
`define RTCM_SECONDS_AND_STOP   5'h01
`define RTCM_MINUTES_COUNT      5'h02
`define RTCM_CENTURY_AND_HOURS  5'h03
`define RTCM_DAY_OF_WEEK        5'h04
`define RTCM_DAY_OF_MONTH       5'h05
`define RTCM_MONTH_COUNT        5'h06
`define RTCM_YEAR_COUNT         5'h07
`define RTCM_DIGITAL_TRIM       5'h08
`define RTCM_WATCHDOG_SETUP     5'h09
`define RTCM_ALARM1_MONTH       5'h0A
`define RTCM_ALARM1_DATE        5'h0B
`define RTCM_ALARM1_HOUR        5'h0C
`define RTCM_ALARM1_MINUTES     5'h0D
`define RTCM_ALARM1_SECONDS     5'h0E
`define RTCM_EVENT_FLAGS        5'h0F
`define RTCM_COUNTDOWN_VALUE    5'h10
`define RTCM_COUNTDOWN_CONTROL  5'h11
`define RTCM_ANALOG_TRIM        5'h12
`define RTCM_ALARM2_SELECT      5'h13
`define RTCM_ALARM2_MONTH       5'h14
`define RTCM_ALARM2_DATE        5'h15
`define RTCM_ALARM2_HOUR        5'h16
`define RTCM_ALARM2_MINUTES     5'h17
`define RTCM_ALARM2_SECONDS     5'h18
`define RTCM_LAST_CLOCK         5'h07

// ****************************************************************
// writable-bit masks (fixed-zero bits cleared)
// ****************************************************************
`define RTCM_MASK_FULL          8'hFF
`define RTCM_MASK_MINUTES       8'h7F
`define RTCM_MASK_DAY_OF_WEEK   8'h07
`define RTCM_MASK_DAY_OF_MONTH  8'h3F
`define RTCM_MASK_MONTH         8'h1F
`define RTCM_MASK_DIGITAL_TRIM  8'h7F
`define RTCM_MASK_WATCHDOG      8'h7F
`define RTCM_MASK_ALARM1_MONTH  8'h3F
`define RTCM_MASK_CD_CONTROL    8'h83
`define RTCM_MASK_ALARM2_SELECT 8'h02
`define RTCM_MASK_ALARM2_MONTH  8'h1F
`define RTCM_MASK_ALARM2_HOUR   8'hBF
`define RTCM_MASK_FLAGS         8'hFC

// ****************************************************************
// field positions
// ****************************************************************
`define RTCM_BIT_STOP           7
`define RTCM_BIT_FREQ_TEST      6
`define RTCM_BIT_DTRIM_SIGN     5
`define RTCM_BIT_BACKUP_ALARM   5
`define RTCM_BIT_RPT_FIFTH      6
`define RTCM_BIT_RPT            7
`define RTCM_BIT_HALT           6
`define RTCM_BIT_TIMER_EN       7
`define RTCM_BIT_ATRIM_SIGN     7
`define RTCM_BIT_ALARM2_EN      1
`define RTCM_FLAG_ALARM2        5

// ****************************************************************
// reset values
// ****************************************************************
`define RTCM_RESET_BYTE         8'h00
`define RTCM_RESET_FLAGS        6'h00

`endif

// ---- rtcm_register_map.v ----
// register map of a serial real-time clock: buffer/transfer bytes,
// calibration, watchdog, alarm, flag, timer and user storage locations.
// assumes a serial bus front end that marks the start and end of each
// transfer and gives byte reads and writes at a five-bit location, and
// timekeeping counters outside that offer their live value and accept a load.
//
// Functional notes
// - thirty-two byte locations, 00h to 1Fh
// - buffer keeps last-access time across power-down
// - second-alarm flag reads zero when disabled
// - 14h-18h full storage bytes when disabled
// - backup alarm enable at 0Ah bit 5
// - first alarm repeat bits, 0Bh-0Eh
// - second alarm repeat bits, 15h-18h
// - 08h holds test, trim sign, magnitude
// - 12h holds analog trim sign, magnitude
// - clock fields BCD, trims binary
// - halt blocks counter copies until cleared
// - clock write reloads counters, resets divider
`timescale 1ns/1ps
`include "rtcm_regs.vh"

module rtcm_register_map (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        xfer_start,
  input  wire        xfer_end,
  input  wire        acc_wr,
  input  wire        acc_rd,
  input  wire [4:0]  acc_loc,
  input  wire [7:0]  acc_wdata,
  output wire [7:0]  acc_rdata,
  input  wire [63:0] live_time,
  input  wire        backup_entry,
  input  wire [5:0]  flag_set,
  output wire        time_load,
  output wire [63:0] time_load_data,
  output wire        divider_reset,
  output wire        oscillator_stop,
  output wire        frequency_test,
  output wire        digital_trim_sign,
  output wire [4:0]  digital_trim_magnitude,
  output wire [4:0]  watchdog_multiplier,
  output wire [1:0]  watchdog_resolution,
  output wire        backup_alarm_enable,
  output wire [4:0]  alarm1_repeat_bits,
  output wire [4:0]  alarm2_repeat_bits,
  output wire        halt_update,
  output wire [5:0]  event_flags,
  output wire [7:0]  countdown_value,
  output wire        timer_enable,
  output wire [1:0]  timer_frequency_select,
  output wire        analog_trim_sign,
  output wire [6:0]  analog_trim_magnitude,
  output wire        second_alarm_enable
);

  localparam DEPTH = 32;

  // ****************************************************************
  // storage
  // ****************************************************************
  reg [7:0]  loc_r [0:DEPTH-1];
  reg [5:0]  flags_r;
  reg        halt_r;
  reg        clk_dirty_r;
  reg        load_r;
  reg [7:0]  rdata_r;
  reg [7:0]  wmask;
  reg [7:0]  rbyte;
  reg [5:0]  flags_nxt;
  reg        halt_nxt;
  wire       alarm2_on;
  wire       wr_clock;
  integer    i;

  assign alarm2_on = loc_r[`RTCM_ALARM2_SELECT][`RTCM_BIT_ALARM2_EN];
  assign wr_clock  = acc_wr && (acc_loc <= `RTCM_LAST_CLOCK);

  // ****************************************************************
  // writable bits per location
  // ****************************************************************
  // writes through the mask, so a write leaves fixed-zero bits at zero; the counter copy into 00h-07h is not masked
  always @* begin
    case (acc_loc)
      `RTCM_MINUTES_COUNT:     wmask = `RTCM_MASK_MINUTES;
      `RTCM_DAY_OF_WEEK:       wmask = `RTCM_MASK_DAY_OF_WEEK;
      `RTCM_DAY_OF_MONTH:      wmask = `RTCM_MASK_DAY_OF_MONTH;
      `RTCM_MONTH_COUNT:       wmask = `RTCM_MASK_MONTH;
      `RTCM_DIGITAL_TRIM:      wmask = `RTCM_MASK_DIGITAL_TRIM;
      `RTCM_WATCHDOG_SETUP:    wmask = `RTCM_MASK_WATCHDOG;
      `RTCM_ALARM1_MONTH:      wmask = `RTCM_MASK_ALARM1_MONTH;
      `RTCM_EVENT_FLAGS:       wmask = `RTCM_MASK_FLAGS;
      `RTCM_COUNTDOWN_CONTROL: wmask = `RTCM_MASK_CD_CONTROL;
      `RTCM_ALARM2_SELECT:     wmask = `RTCM_MASK_ALARM2_SELECT;
      `RTCM_ALARM2_MONTH:
        wmask = alarm2_on ? `RTCM_MASK_ALARM2_MONTH : `RTCM_MASK_FULL;
      `RTCM_ALARM2_HOUR:
        wmask = alarm2_on ? `RTCM_MASK_ALARM2_HOUR : `RTCM_MASK_FULL;
      default:                 wmask = `RTCM_MASK_FULL;
    endcase
  end

  // ****************************************************************
  // flag and halt next values
  // ****************************************************************
  // hardware set wins over a clearing write in the same cycle
  always @* begin
    flags_nxt = flags_r;
    if (acc_wr && acc_loc == `RTCM_EVENT_FLAGS) begin
      flags_nxt = acc_wdata[7:2];
    end
    flags_nxt = flags_nxt | flag_set;
    halt_nxt  = halt_r;
    if (acc_wr && acc_loc == `RTCM_ALARM1_HOUR) begin
      halt_nxt = acc_wdata[`RTCM_BIT_HALT];
    end
    if (backup_entry) begin
      halt_nxt = 1'b1;
    end
  end

  // ****************************************************************
  // location array, buffer capture and write-back
  // ****************************************************************
  // thirty-two byte locations
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        loc_r[i] <= `RTCM_RESET_BYTE;
      end
      flags_r     <= `RTCM_RESET_FLAGS;
      halt_r      <= 1'b0;
      clk_dirty_r <= 1'b0;
      load_r      <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      halt_r  <= halt_nxt;
      load_r  <= 1'b0;
      if (xfer_start && !halt_r) begin
        for (i = 0; i <= `RTCM_LAST_CLOCK; i = i + 1) begin
          loc_r[i] <= live_time[i*8 +: 8];
        end
      end
      if (xfer_start) begin
        clk_dirty_r <= 1'b0;
      end
      if (acc_wr) begin
        loc_r[acc_loc] <= acc_wdata & wmask;
      end
      if (wr_clock) begin
        clk_dirty_r <= 1'b1;
      end
      if (xfer_end && (clk_dirty_r || wr_clock)) begin
        load_r      <= 1'b1;
        clk_dirty_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // selects the byte for a read, with special flag and halt views
  always @* begin
    rbyte = loc_r[acc_loc];
    case (acc_loc)
      `RTCM_EVENT_FLAGS: begin
        rbyte = {flags_r, 2'b00};
        if (!alarm2_on) begin
          rbyte[`RTCM_FLAG_ALARM2] = 1'b0;
        end
      end
      `RTCM_ALARM1_HOUR: begin
        rbyte[`RTCM_BIT_HALT] = halt_r;
      end
      default: begin
        rbyte = loc_r[acc_loc];
      end
    endcase
  end

  // read data registered one cycle after the request
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= `RTCM_RESET_BYTE;
    end else if (acc_rd) begin
      rdata_r <= rbyte;
    end
  end

  assign acc_rdata = rdata_r;

  // ****************************************************************
  // counter load and control outputs
  // ****************************************************************
  // eight timekeeping bytes to counters
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_load
      assign time_load_data[g*8 +: 8] = loc_r[g];
    end
  endgenerate

  assign time_load     = load_r;
  assign divider_reset = load_r;

  assign oscillator_stop        = loc_r[`RTCM_SECONDS_AND_STOP][`RTCM_BIT_STOP];
  assign frequency_test         = loc_r[`RTCM_DIGITAL_TRIM][`RTCM_BIT_FREQ_TEST];
  assign digital_trim_sign      = loc_r[`RTCM_DIGITAL_TRIM][`RTCM_BIT_DTRIM_SIGN];
  assign digital_trim_magnitude = loc_r[`RTCM_DIGITAL_TRIM][4:0];
  assign watchdog_multiplier    = loc_r[`RTCM_WATCHDOG_SETUP][6:2];
  assign watchdog_resolution    = loc_r[`RTCM_WATCHDOG_SETUP][1:0];
  assign backup_alarm_enable    = loc_r[`RTCM_ALARM1_MONTH][`RTCM_BIT_BACKUP_ALARM];

  assign alarm1_repeat_bits = {loc_r[`RTCM_ALARM1_DATE][`RTCM_BIT_RPT_FIFTH],
                               loc_r[`RTCM_ALARM1_DATE][`RTCM_BIT_RPT],
                               loc_r[`RTCM_ALARM1_HOUR][`RTCM_BIT_RPT],
                               loc_r[`RTCM_ALARM1_MINUTES][`RTCM_BIT_RPT],
                               loc_r[`RTCM_ALARM1_SECONDS][`RTCM_BIT_RPT]};
  assign alarm2_repeat_bits = {loc_r[`RTCM_ALARM2_DATE][`RTCM_BIT_RPT_FIFTH],
                               loc_r[`RTCM_ALARM2_DATE][`RTCM_BIT_RPT],
                               loc_r[`RTCM_ALARM2_HOUR][`RTCM_BIT_RPT],
                               loc_r[`RTCM_ALARM2_MINUTES][`RTCM_BIT_RPT],
                               loc_r[`RTCM_ALARM2_SECONDS][`RTCM_BIT_RPT]};

  assign halt_update  = halt_r;
  assign event_flags  = {flags_r[5:4], flags_r[3] & alarm2_on, flags_r[2:0]};

  assign countdown_value        = loc_r[`RTCM_COUNTDOWN_VALUE];
  assign timer_enable           = loc_r[`RTCM_COUNTDOWN_CONTROL][`RTCM_BIT_TIMER_EN];
  assign timer_frequency_select = loc_r[`RTCM_COUNTDOWN_CONTROL][1:0];
  assign analog_trim_sign       = loc_r[`RTCM_ANALOG_TRIM][`RTCM_BIT_ATRIM_SIGN];
  assign analog_trim_magnitude  = loc_r[`RTCM_ANALOG_TRIM][6:0];
  assign second_alarm_enable    = alarm2_on;

endmodule // rtcm_register_map

// ---- rtcm_map_checker.sv ----
// concurrent checks on the register map ports
// assumes it is bound onto every rtcm_register_map instance
`timescale 1ns/1ps
module rtcm_map_checker (
  input wire        sys_clk,
  input wire        sys_rst,
  input wire        xfer_start,
  input wire        xfer_end,
  input wire        acc_wr,
  input wire        acc_rd,
  input wire [4:0]  acc_loc,
  input wire [7:0]  acc_wdata,
  input wire [7:0]  acc_rdata,
  input wire [63:0] live_time,
  input wire        backup_entry,
  input wire        time_load,
  input wire [63:0] time_load_data,
  input wire        divider_reset,
  input wire        digital_trim_sign,
  input wire        backup_alarm_enable,
  input wire        halt_update,
  input wire        analog_trim_sign,
  input wire [6:0]  analog_trim_magnitude,
  input wire        second_alarm_enable
);
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb_sys @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // a transfer that writes one clock location
  sequence s_clock_write;
    xfer_start ##1 (acc_wr && acc_loc <= 5'h07) ##1 xfer_end;
  endsequence
  reload_after_write_a: assert property (s_clock_write |=> time_load && divider_reset)
    else $error("no counter reload after clock write");
  load_single_a: assert property (time_load |=> !time_load)
    else $error("counter load longer than one cycle");
  load_cause_a: assert property (time_load |-> $past(xfer_end))
    else $error("counter load without transfer end");
  divider_pair_a: assert property (divider_reset == time_load)
    else $error("divider reset apart from counter load");
  buffer_copy_a: assert property ((xfer_start && !halt_update && !acc_wr)
    |=> time_load_data == $past(live_time)) else $error("buffer missed counter copy");
  halt_freeze_a: assert property ((xfer_start && halt_update && !acc_wr)
    |=> $stable(time_load_data)) else $error("buffer changed while halted");
  halt_entry_a: assert property (backup_entry |=> halt_update)
    else $error("halt not set on backup entry");
  halt_clear_a: assert property ((acc_wr && acc_loc == 5'h0C && !acc_wdata[6]
    && !backup_entry) |=> !halt_update) else $error("halt not cleared by write");
  flag_low_a: assert property ((acc_rd && acc_loc == 5'h0F) |=> acc_rdata[1:0] == 2'h0)
    else $error("flag low bits not zero");
  alarm2_hidden_a: assert property ((acc_rd && acc_loc == 5'h0F && !second_alarm_enable)
    |=> !acc_rdata[5]) else $error("second alarm flag visible while disabled");
  trim_sign_a: assert property ((acc_wr && acc_loc == 5'h08)
    |=> digital_trim_sign == $past(acc_wdata[5])) else $error("trim sign not written");
  analog_trim_a: assert property ((acc_wr && acc_loc == 5'h12)
    |=> {analog_trim_sign, analog_trim_magnitude} == $past(acc_wdata))
    else $error("analog trim not written");
  backup_alarm_a: assert property ((acc_wr && acc_loc == 5'h0A)
    |=> backup_alarm_enable == $past(acc_wdata[5])) else $error("backup alarm not written");
endmodule // rtcm_map_checker

bind rtcm_register_map rtcm_map_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .xfer_start(xfer_start), .xfer_end(xfer_end), .acc_wr(acc_wr), .acc_rd(acc_rd),
  .acc_loc(acc_loc), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .live_time(live_time),
  .backup_entry(backup_entry), .time_load(time_load), .time_load_data(time_load_data),
  .divider_reset(divider_reset), .digital_trim_sign(digital_trim_sign),
  .backup_alarm_enable(backup_alarm_enable), .halt_update(halt_update),
  .analog_trim_sign(analog_trim_sign), .analog_trim_magnitude(analog_trim_magnitude),
  .second_alarm_enable(second_alarm_enable));

// ---- rtcm_host_model.sv ----
// serial bus host model: transfer framing and byte access tasks
// assumes the bench calls its tasks hierarchically after reset
`timescale 1ns/1ps
module rtcm_host_model (
  input  wire       sys_clk,
  input  wire [7:0] acc_rdata,
  output reg        xfer_start,
  output reg        xfer_end,
  output reg        acc_wr,
  output reg        acc_rd,
  output reg  [4:0] acc_loc,
  output reg  [7:0] acc_wdata
);
  // ****************************************************************
  // bus tasks, all driven at the falling edge
  // ****************************************************************
  initial begin
    {xfer_start, xfer_end, acc_wr, acc_rd, acc_loc, acc_wdata} = 17'h0_0000;
  end
  // framing for periodic polls, s high opens, low closes
  task frame(input logic s);
    begin
      @(negedge sys_clk);
      xfer_start = s;
      xfer_end = !s;
      @(negedge sys_clk);
      xfer_start = 1'b0;
      xfer_end = 1'b0;
    end
  endtask
  // byte write, released lines show inverted values
  task write_byte(input logic [4:0] l, input logic [7:0] d);
    begin
      @(negedge sys_clk);
      acc_wr = 1'b1;
      acc_loc = l;
      acc_wdata = d;
      @(negedge sys_clk);
      acc_wr = 1'b0;
      acc_loc = ~l;
      acc_wdata = ~d;
    end
  endtask
  // byte read, data taken one cycle after the request
  task read_byte(input logic [4:0] l, output logic [7:0] d);
    begin
      @(negedge sys_clk);
      acc_rd = 1'b1;
      acc_loc = l;
      @(negedge sys_clk);
      acc_rd = 1'b0;
      acc_loc = ~l;
      d = acc_rdata;
    end
  endtask
endmodule // rtcm_host_model

// ---- rtcm_register_map_tb_top.sv ----
// self-checking bench for the register map
// assumes the host model drives the access side
`timescale 1ns/1ps
module rtcm_register_map_tb_top;
  reg sys_clk, sys_rst, backup_entry;
  reg [63:0] live_time;
  reg [5:0] flag_set;
  wire xs, xe, wr, rdq, tl, dr, ost, ft, dts, bae, hu, te, ats, ae;
  wire [4:0] loc, dtm, wm, r1, r2;
  wire [7:0] wd, rdata, cdv;
  wire [63:0] tld;
  wire [1:0] wres, tfs;
  wire [5:0] ef;
  wire [6:0] atm;
  integer error_cnt, num_checks, cyc, i;
  logic [7:0] rd;
  rtcm_host_model u_host (.sys_clk(sys_clk), .acc_rdata(rdata), .xfer_start(xs),
    .xfer_end(xe), .acc_wr(wr), .acc_rd(rdq), .acc_loc(loc), .acc_wdata(wd));
  rtcm_register_map u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .xfer_start(xs),
    .xfer_end(xe), .acc_wr(wr), .acc_rd(rdq), .acc_loc(loc), .acc_wdata(wd),
    .acc_rdata(rdata), .live_time(live_time), .backup_entry(backup_entry),
    .flag_set(flag_set), .time_load(tl), .time_load_data(tld), .divider_reset(dr),
    .oscillator_stop(ost), .frequency_test(ft), .digital_trim_sign(dts),
    .digital_trim_magnitude(dtm), .watchdog_multiplier(wm), .watchdog_resolution(wres),
    .backup_alarm_enable(bae), .alarm1_repeat_bits(r1), .alarm2_repeat_bits(r2),
    .halt_update(hu), .event_flags(ef), .countdown_value(cdv), .timer_enable(te),
    .timer_frequency_select(tfs), .analog_trim_sign(ats), .analog_trim_magnitude(atm),
    .second_alarm_enable(ae));
  // ****************************************************************
  // clock, timeout, compare and verdict
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // readback of all ones with fixed-zero bits dropped, in loop order
  function logic [7:0] ones_back(input logic [4:0] l);
    case (l)
      5'h08, 5'h09: ones_back = 8'h7F;
      5'h0A: ones_back = 8'h3F;
      5'h0F: ones_back = 8'hDC;
      5'h11: ones_back = 8'h83;
      5'h13: ones_back = 8'h02;
      5'h14: ones_back = 8'h1F;
      5'h16: ones_back = 8'hBF;
      default: ones_back = 8'hFF;
    endcase
  endfunction
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    {error_cnt, num_checks, cyc} = 0;
    {sys_rst, backup_entry, flag_set, live_time} = {1'b1, 1'b0, 6'h00, 64'h0123_4567_89AB_CDEF};
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'b0;
    for (i = 8; i < 32; i = i + 1) begin
      u_host.read_byte(i[4:0], rd);
      check("reset value", rd, 8'h00);
      u_host.write_byte(i[4:0], 8'hFF);
      u_host.read_byte(i[4:0], rd);
      check("ones readback", rd, ones_back(i[4:0]));
    end
    check("digital trim", {ft, dts, dtm}, 7'h7F);
    check("analog trim", {ats, atm}, 8'hFF);
    check("repeat bits", {r1, r2}, 10'h3FF);
    check("watchdog", {wm, wres, bae, te, tfs}, 11'h7FF);
    check("countdown", cdv, 8'hFF);
    u_host.write_byte(5'h13, 8'h00);
    u_host.write_byte(5'h0F, 8'h00);
    for (i = 20; i < 23; i = i + 2) begin
      u_host.write_byte(i[4:0], 8'hFF);
      u_host.read_byte(i[4:0], rd);
      check("storage byte", rd, 8'hFF);
    end
    @(negedge sys_clk) flag_set = 6'h08;
    @(negedge sys_clk) flag_set = 6'h00;
    u_host.read_byte(5'h0F, rd);
    check("hidden flag", rd, 8'h00);
    u_host.write_byte(5'h13, 8'h02);
    u_host.read_byte(5'h0F, rd);
    check("shown flag", rd, 8'h20);
    @(negedge sys_clk) flag_set = 6'h3F;
    @(negedge sys_clk) flag_set = 6'h00;
    u_host.read_byte(5'h0F, rd);
    check("all flags", rd, 8'hFC);
    check("flag outputs", ef, 6'h3F);
    u_host.write_byte(5'h13, 8'h00);
    check("masked flag output", ef, 6'h37);
    u_host.write_byte(5'h0C, 8'h00);
    u_host.frame(1'b1);
    u_host.frame(1'b0);
    @(negedge sys_clk) backup_entry = 1'b1;
    @(negedge sys_clk) backup_entry = 1'b0;
    check("halt set", hu, 1'b1);
    live_time = ~live_time;
    u_host.frame(1'b1);
    u_host.read_byte(5'h03, rd);
    u_host.frame(1'b0);
    check("frozen time", rd, 8'h89);
    u_host.write_byte(5'h0C, 8'h00);
    u_host.frame(1'b1);
    u_host.read_byte(5'h03, rd);
    u_host.frame(1'b0);
    check("present time", rd, 8'h76);
    live_time = 64'h0123_4567_89AB_CDEF;
    u_host.frame(1'b1);
    u_host.write_byte(5'h19, 8'h11);
    u_host.frame(1'b0);
    check("no reload", {tl, dr}, 2'h0);
    u_host.frame(1'b1);
    u_host.write_byte(5'h01, 8'h45);
    u_host.frame(1'b0);
    check("reload", {tl, dr, tld}, {2'h3, 64'h0123_4567_89AB_45EF});
    @(negedge sys_clk);
    check("reload ends", {tl, dr}, 2'h0);
    check("stop bit", ost, 1'b0);
    report_and_stop;
  end
endmodule // rtcm_register_map_tb_top
